// ===== design/wos_defs.svh
// Register map, field positions, reset values and timing counts of the sequencer
`ifndef WOS_DEFS_SVH
`define WOS_DEFS_SVH

`define WOS_ADDR_CTRL       8'h00
`define WOS_ADDR_STATUS     8'h04
`define WOS_ADDR_FIFO       8'h08
`define WOS_ADDR_COUNT      8'h0C
`define WOS_ADDR_PERIOD     8'h10
`define WOS_ADDR_DELAY      8'h14
`define WOS_ADDR_TBDIV      8'h18
`define WOS_ADDR_OUTPUT     8'h1C

`define WOS_CTRL_START      0
`define WOS_CTRL_STOP       1
`define WOS_CTRL_SWUPD      2
`define WOS_CTRL_MODE       4
`define WOS_CTRL_HWT        6
`define WOS_CTRL_EXTCLK     7
`define WOS_CTRL_TRIGEN     8
`define WOS_CTRL_PAUSEPOL   9
`define WOS_CTRL_FALLING    10
`define WOS_CTRL_PAUSEEN    11

`define WOS_ST_RUNNING      0
`define WOS_ST_ARMED        1
`define WOS_ST_UNDERFLOW    2
`define WOS_ST_DONE         3
`define WOS_ST_REFUSED      4
`define WOS_ST_FULL         5
`define WOS_ST_EMPTY        6
`define WOS_ST_PAUSED       7
`define WOS_ST_LEVEL        16

`define WOS_SAMPLE_W        16
`define WOS_AW              8
`define WOS_DEPTH           9'h100

`define WOS_CLK_PERIOD_NS   5
`define WOS_TB_PERIOD_NS    50
`define WOS_TBDIV_RST       16'(`WOS_TB_PERIOD_NS / `WOS_CLK_PERIOD_NS)
`define WOS_DELAY_RST       16'h0002
`define WOS_PERIOD_RST      24'h00_0002
`define WOS_COUNT_RST       32'h0000_0001

`endif

// ===== design/wos_pkg.sv
// Types shared by the waveform output sequencer modules
package wos_pkg;
`include "wos_defs.svh"

    typedef enum logic [1:0] {WOS_FINITE, WOS_REGEN, WOS_FIFO_REGEN, WOS_NONREGEN} wos_mode_e;
    typedef enum logic [1:0] {WOS_IDLE, WOS_ARMED, WOS_RUN} wos_state_e;

    typedef logic [`WOS_SAMPLE_W-1:0] wos_sample_t;
    typedef logic [`WOS_AW-1:0]       wos_ptr_t;

    typedef struct packed {
        logic [15:0] tb_cnt;
        logic [23:0] cnt;
        logic        active;
        logic        tick;
    } wos_timer_s;

    typedef struct packed {
        wos_state_e       st;
        wos_mode_e        mode;
        logic             hw_timed;
        logic             ext_clk;
        logic             trig_en;
        logic             pause_pol;
        logic             start_falling;
        logic             pause_en;
        logic [31:0]      sample_count;
        logic [23:0]      period;
        logic [15:0]      delay;
        logic [15:0]      tb_div;
        wos_ptr_t         wp;
        wos_ptr_t         rp;
        wos_ptr_t         base;
        logic [8:0]       level;
        logic [31:0]      remaining;
        logic             underflow;
        logic             done;
        logic             refused;
        wos_sample_t [1:0] ch;
        logic             upd;
        logic             clk_out;
        logic             gen_act;
        logic             launch;
        logic             trig_prev;
        logic             ext_prev;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } wos_state_s;

endpackage : wos_pkg

// ===== design/wos_sample_mem.sv
// Sample storage of the output FIFO, registered read with write-through
`timescale 1ns/1ps
`include "wos_defs.svh"
module wos_sample_mem (
    // Clock
    input  wire logic          pclk,
    // Write side
    input  wire logic          we,
    input  wire wos_pkg::wos_ptr_t waddr,
    input  wire logic [31:0]   wdata,
    // Read side
    input  wire wos_pkg::wos_ptr_t raddr,
    output logic [31:0]        rdata
);
    import wos_pkg::*;

    logic [31:0] mem [0:`WOS_DEPTH-1];

    // Write-through so a sample pushed into an empty FIFO is seen at once
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (we && waddr == raddr) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : wos_sample_mem

// ===== design/wos_update_timer.sv
// Timebase divider and sample counter making the internal update ticks
`timescale 1ns/1ps
module wos_update_timer (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Control
    input  wire logic        launch,
    input  wire logic        run,
    input  wire logic [15:0] tb_div,
    input  wire logic [23:0] period,
    input  wire logic [15:0] delay,
    // Tick out
    output logic             tick
);
    import wos_pkg::*;

    wos_timer_s s_q;
    wos_timer_s s_d;
    logic       tb_tick;

    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        tb_tick  = (tb_div <= 16'h0001) || (s_q.tb_cnt >= tb_div - 16'h0001);
        s_d.tb_cnt = tb_tick ? 16'h0000 : s_q.tb_cnt + 16'h0001;
        if (launch) begin
            // First tick after the programmed delay in timebase ticks
            s_d.active = 1'b1;
            s_d.cnt    = {8'h00, delay};
            s_d.tb_cnt = 16'h0000;
        end else if (!run) begin
            s_d.active = 1'b0;
        end else if (s_q.active && tb_tick) begin
            if (s_q.cnt <= 24'h00_0001) begin
                s_d.tick = 1'b1;
                s_d.cnt  = period;
            end else begin
                s_d.cnt = s_q.cnt - 24'h00_0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule : wos_update_timer

// ===== design/wos_sequencer.sv
// Two-channel waveform output sequencer with APB registers and output FIFO
//
// Summary of operation
// - each update plays one FIFO sample
// - FIFO holds waveform for host-free playout
// - software update command gives exactly one update
// - hardware timing from internal or external clock
// - host fills FIFO; device plays one per update
// - finite mode stops after programmed count
// - continuous modes run until stop or, in non-regeneration, until underflow
// - standard regeneration plays FIFO as host refills
// - FIFO regeneration replays; writes refused after start
// - non-regeneration never repeats; reports underflow
// - non-buffered writes output at next tick (not built here: every sample goes through the FIFO)
// - start and pause triggers gate generation
// - two output channels, zero and one
// - one update clock moves both channels
// - pause suppresses ticks from next sample
// - start launches counter; delay defaults two
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "wos_defs.svh"
module wos_sequencer (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Trigger and external clock inputs
    input  wire logic        generation_start_trigger,
    input  wire logic        generation_pause_trigger,
    input  wire logic        output_update_clock_in,
    // Converter side
    output wos_pkg::wos_sample_t output_channel_zero,
    output wos_pkg::wos_sample_t output_channel_one,
    output logic             converter_update,
    output logic             output_update_clock,
    output logic             generation_active
);
    import wos_pkg::*;

    wos_state_s  s_q;
    wos_state_s  s_d;
    logic [31:0] mem_rdata;
    logic        mem_we;
    wos_sample_t mem_ch [1:0];
    logic        timer_tick;
    logic        wr_done;
    logic        rd_acc;
    logic        trig_edge;
    logic        ext_edge;
    logic        paused;
    logic        tick;
    logic        pop;
    logic        locked;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Both channels come from one FIFO word
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            assign mem_ch[gi] = mem_rdata[gi*`WOS_SAMPLE_W +: `WOS_SAMPLE_W];
        end
    endgenerate

    always_comb begin
        s_d        = s_q;
        s_d.upd    = 1'b0;
        s_d.clk_out = 1'b0;
        s_d.launch = 1'b0;
        mem_we     = 1'b0;
        pop        = 1'b0;
        s_d.trig_prev = generation_start_trigger;
        s_d.ext_prev  = output_update_clock_in;

        // APB: one wait state, effects land on the completing edge
        s_d.pready = psel && penable && !s_q.pready;
        wr_done    = psel && penable && s_q.pready && pwrite;
        rd_acc     = psel && penable && !s_q.pready && !pwrite;
        locked     = (s_q.mode == WOS_FIFO_REGEN) && (s_q.st != WOS_IDLE);

        trig_edge = s_q.start_falling ? (s_q.trig_prev && !generation_start_trigger)
                                      : (!s_q.trig_prev && generation_start_trigger);
        ext_edge  = !s_q.ext_prev && output_update_clock_in;
        paused    = s_q.pause_en && (generation_pause_trigger ^ s_q.pause_pol);

        // Pause gates only whole ticks, an update never stops halfway
        if (!s_q.hw_timed) begin
            tick = wr_done && hit(paddr, `WOS_ADDR_CTRL) && pwdata[`WOS_CTRL_SWUPD];
        end else begin
            tick = (s_q.ext_clk ? ext_edge : timer_tick) && !paused;
        end

        // Register reads
        if (rd_acc) begin
            s_d.pslverr = 1'b0;
            case (paddr)
                `WOS_ADDR_CTRL: begin
                    s_d.prdata = '0;
                    s_d.prdata[`WOS_CTRL_MODE +: 2]  = s_q.mode;
                    s_d.prdata[`WOS_CTRL_HWT]        = s_q.hw_timed;
                    s_d.prdata[`WOS_CTRL_EXTCLK]     = s_q.ext_clk;
                    s_d.prdata[`WOS_CTRL_TRIGEN]     = s_q.trig_en;
                    s_d.prdata[`WOS_CTRL_PAUSEPOL]   = s_q.pause_pol;
                    s_d.prdata[`WOS_CTRL_FALLING]    = s_q.start_falling;
                    s_d.prdata[`WOS_CTRL_PAUSEEN]    = s_q.pause_en;
                end
                `WOS_ADDR_STATUS: begin
                    s_d.prdata = '0;
                    s_d.prdata[`WOS_ST_RUNNING]   = (s_q.st == WOS_RUN);
                    s_d.prdata[`WOS_ST_ARMED]     = (s_q.st == WOS_ARMED);
                    s_d.prdata[`WOS_ST_UNDERFLOW] = s_q.underflow;
                    s_d.prdata[`WOS_ST_DONE]      = s_q.done;
                    s_d.prdata[`WOS_ST_REFUSED]   = s_q.refused;
                    s_d.prdata[`WOS_ST_FULL]      = (s_q.level == `WOS_DEPTH);
                    s_d.prdata[`WOS_ST_EMPTY]     = (s_q.level == 9'h000);
                    s_d.prdata[`WOS_ST_PAUSED]    = paused;
                    s_d.prdata[`WOS_ST_LEVEL +: 9] = s_q.level;
                end
                `WOS_ADDR_COUNT:  s_d.prdata = s_q.sample_count;
                `WOS_ADDR_PERIOD: s_d.prdata = {8'h00, s_q.period};
                `WOS_ADDR_DELAY:  s_d.prdata = {16'h0000, s_q.delay};
                `WOS_ADDR_TBDIV:  s_d.prdata = {16'h0000, s_q.tb_div};
                `WOS_ADDR_OUTPUT: s_d.prdata = {s_q.ch[1], s_q.ch[0]};
                `WOS_ADDR_FIFO:   s_d.prdata = 32'h0000_0000;
                default: begin
                    s_d.prdata  = 32'h0000_0000;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end else if (psel && penable && !s_q.pready) begin
            s_d.prdata  = 32'h0000_0000;
            s_d.pslverr = !(hit(paddr, `WOS_ADDR_CTRL) || hit(paddr, `WOS_ADDR_STATUS)
                         || hit(paddr, `WOS_ADDR_FIFO) || hit(paddr, `WOS_ADDR_COUNT)
                         || hit(paddr, `WOS_ADDR_PERIOD) || hit(paddr, `WOS_ADDR_DELAY)
                         || hit(paddr, `WOS_ADDR_TBDIV) || hit(paddr, `WOS_ADDR_OUTPUT));
            if (hit(paddr, `WOS_ADDR_FIFO) && (locked || s_q.level == `WOS_DEPTH)) begin
                s_d.pslverr = 1'b1;
            end
        end else begin
            // Error stands only alongside pready
            s_d.pslverr = 1'b0;
        end

        // Register writes; sticky flags cleared here, set below wins
        if (wr_done) begin
            case (paddr)
                `WOS_ADDR_CTRL: begin
                    if (s_q.st == WOS_IDLE) begin
                        s_d.mode          = wos_mode_e'(pwdata[`WOS_CTRL_MODE +: 2]);
                        s_d.hw_timed      = pwdata[`WOS_CTRL_HWT];
                        s_d.ext_clk       = pwdata[`WOS_CTRL_EXTCLK];
                        s_d.trig_en       = pwdata[`WOS_CTRL_TRIGEN];
                        s_d.start_falling = pwdata[`WOS_CTRL_FALLING];
                    end
                    s_d.pause_pol = pwdata[`WOS_CTRL_PAUSEPOL];
                    s_d.pause_en  = pwdata[`WOS_CTRL_PAUSEEN];
                end
                `WOS_ADDR_STATUS: begin
                    if (pwdata[`WOS_ST_UNDERFLOW]) s_d.underflow = 1'b0;
                    if (pwdata[`WOS_ST_DONE])      s_d.done      = 1'b0;
                    if (pwdata[`WOS_ST_REFUSED])   s_d.refused   = 1'b0;
                end
                `WOS_ADDR_COUNT:  s_d.sample_count = pwdata;
                `WOS_ADDR_PERIOD: s_d.period = pwdata[23:0];
                `WOS_ADDR_DELAY:  s_d.delay  = pwdata[15:0];
                `WOS_ADDR_TBDIV:  s_d.tb_div = pwdata[15:0];
                `WOS_ADDR_FIFO: begin
                    if (locked) begin
                        s_d.refused = 1'b1;
                    end else if (s_q.level != `WOS_DEPTH) begin
                        mem_we = 1'b1;
                        s_d.wp = s_q.wp + 8'h01;
                    end
                end
                default: ;
            endcase
        end

        // Sequencing
        case (s_q.st)
            WOS_IDLE: begin
                if (wr_done && hit(paddr, `WOS_ADDR_CTRL) && pwdata[`WOS_CTRL_START]
                    && !pwdata[`WOS_CTRL_STOP]) begin
                    s_d.done = 1'b0;
                    if (pwdata[`WOS_CTRL_TRIGEN] && pwdata[`WOS_CTRL_HWT]) begin
                        s_d.st = WOS_ARMED;
                    end else begin
                        s_d.st     = WOS_RUN;
                        s_d.launch = 1'b1;
                    end
                end
            end
            WOS_ARMED: begin
                if (trig_edge) begin
                    s_d.st     = WOS_RUN;
                    s_d.launch = 1'b1;
                end
            end
            WOS_RUN: begin
                if (tick) begin
                    if (s_q.level != 9'h000) begin
                        // Both converters load in the same cycle
                        s_d.ch[0]  = mem_ch[0];
                        s_d.ch[1]  = mem_ch[1];
                        s_d.upd    = 1'b1;
                        s_d.clk_out = s_q.hw_timed;
                        if (s_q.mode == WOS_FIFO_REGEN) begin
                            // Entries stay, only the play pointer moves
                            s_d.rp = (s_q.rp + 8'h01 == s_q.wp) ? s_q.base
                                                                : s_q.rp + 8'h01;
                        end else begin
                            pop = 1'b1;
                            s_d.rp = s_q.rp + 8'h01;
                        end
                        if (s_q.mode == WOS_FINITE) begin
                            s_d.remaining = s_q.remaining - 32'h0000_0001;
                            if (s_q.remaining <= 32'h0000_0001) begin
                                s_d.st   = WOS_IDLE;
                                s_d.done = 1'b1;
                            end
                        end
                    end else if (s_q.mode == WOS_NONREGEN) begin
                        s_d.underflow = 1'b1;
                        s_d.st        = WOS_IDLE;
                    end
                end
            end
            default: s_d.st = WOS_IDLE;
        endcase

        // Stop holds in every state; regeneration modes end only here
        if (wr_done && hit(paddr, `WOS_ADDR_CTRL) && pwdata[`WOS_CTRL_STOP]) begin
            s_d.st = WOS_IDLE;
        end

        if (s_d.launch) begin
            s_d.base      = s_q.rp;
            s_d.remaining = s_q.sample_count;
        end
        s_d.level = s_q.level + {8'h00, mem_we} - {8'h00, pop};
        // Run flag leaves a flip-flop, not a decode
        s_d.gen_act = (s_d.st == WOS_RUN);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q              <= '0;
            s_q.st           <= WOS_IDLE;
            s_q.mode         <= WOS_FINITE;
            s_q.sample_count <= `WOS_COUNT_RST;
            s_q.period       <= `WOS_PERIOD_RST;
            s_q.delay        <= `WOS_DELAY_RST;
            s_q.tb_div       <= `WOS_TBDIV_RST;
        end else begin
            s_q <= s_d;
        end
    end

    wos_sample_mem u_mem (
        .pclk  (pclk),
        .we    (mem_we),
        .waddr (s_q.wp),
        .wdata (pwdata),
        .raddr (s_d.rp),
        .rdata (mem_rdata)
    );

    wos_update_timer u_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .launch  (s_q.launch),
        .run     (s_q.st == WOS_RUN && s_q.hw_timed && !s_q.ext_clk),
        .tb_div  (s_q.tb_div),
        .period  (s_q.period),
        .delay   (s_q.delay),
        .tick    (timer_tick)
    );

    assign prdata              = s_q.prdata;
    assign pready              = s_q.pready;
    assign pslverr             = s_q.pslverr;
    assign output_channel_zero = s_q.ch[0];
    assign output_channel_one  = s_q.ch[1];
    assign converter_update    = s_q.upd;
    assign output_update_clock = s_q.clk_out;
    assign generation_active   = s_q.gen_act;
endmodule : wos_sequencer

// ===== bench/wos_seq_assertions.sv
// Port-level checker for the waveform output sequencer
`timescale 1ns/1ps
module wos_seq_checker (
    // Clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // APB
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // Converter side
    input wire wos_pkg::wos_sample_t output_channel_zero,
    input wire wos_pkg::wos_sample_t output_channel_one,
    input wire logic                 converter_update,
    input wire logic                 output_update_clock,
    input wire logic                 generation_active
);
    import wos_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("pready held past one cycle");
    property p_ready_wait; psel && $rose(penable) |=> pready; endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("no answer in second access cycle");
    property p_setup_quiet; psel && !penable |-> !pready; endproperty
    a_setup_quiet: assert property (p_setup_quiet)
        else $error("answer during setup cycle");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error flag without ready");
    property p_clk_upd; output_update_clock |-> converter_update; endproperty
    a_clk_upd: assert property (p_clk_upd)
        else $error("update clock without converter update");
    property p_codes_hold;
        !converter_update |-> $stable(output_channel_zero) && $stable(output_channel_one);
    endproperty
    a_codes_hold: assert property (p_codes_hold)
        else $error("codes moved without an update");
    property p_upd_run; converter_update |-> $past(generation_active); endproperty
    a_upd_run: assert property (p_upd_run)
        else $error("update while not generating");
    property p_quiet_end; $fell(generation_active) |=> !converter_update [*3]; endproperty
    a_quiet_end: assert property (p_quiet_end)
        else $error("update after generation ended");
endmodule : wos_seq_checker

bind wos_sequencer wos_seq_checker u_wos_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .output_channel_zero(output_channel_zero),
    .output_channel_one(output_channel_one), .converter_update(converter_update),
    .output_update_clock(output_update_clock), .generation_active(generation_active)
);

// ===== bench/wos_host_model.sv
// Host model: APB master that loads the output FIFO and writes control
`timescale 1ns/1ps
`include "wos_defs.svh"
module wos_host_model (
    // Clock
    input  wire logic        pclk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'h0;
    end

    // Only the bench timeout ends the wait for pready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines show a changed pattern, not the stale one
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer

    task automatic push(input logic [31:0] w, output logic err);
        logic [31:0] unused_rd;
        xfer(1'b1, `WOS_ADDR_FIFO, w, unused_rd, err);
    endtask : push
endmodule : wos_host_model

// ===== bench/wos_sequencer_tb.sv
// Self-checking bench for the waveform output sequencer
`timescale 1ns/1ps
`include "wos_defs.svh"
module wos_sequencer_tb;
    import wos_pkg::*;
    localparam logic [31:0] GO = 32'h1 << `WOS_CTRL_START;
    localparam logic [31:0] HW = 32'h1 << `WOS_CTRL_HWT;
    localparam logic [31:0] TG = 32'h1 << `WOS_CTRL_TRIGEN;
    localparam logic [31:0] PS = 32'h1 << `WOS_CTRL_PAUSEEN;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic        start_trig, pause_trig, ext_clk, conv_upd, upd_clk, gen_active, er_v, hw_exp;
    wos_sample_t ch0, ch1;
    logic [31:0] exp_q[$], pend[$];
    int          errors, checked, cycles;

    wos_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .generation_start_trigger(start_trig),
        .generation_pause_trigger(pause_trig), .output_update_clock_in(ext_clk),
        .output_channel_zero(ch0), .output_channel_one(ch1), .converter_update(conv_upd),
        .output_update_clock(upd_clk), .generation_active(gen_active));
    wos_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : check
    task automatic give_verdict;
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd_v, er_v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
        host.xfer(1'b0, a, 32'h0, rd_v, er_v);
        check(rd_v & m, want);
    endtask : rd
    task automatic load(input int n);
        logic [31:0] w;
        pend.delete();
        for (int i = 0; i < n; i++) begin
            w = $urandom;
            pend.push_back(w);
            host.push(w, er_v);
        end
    endtask : load
    task automatic drain(input bit to_idle);
        while (exp_q.size() != 0) @(posedge pclk);
        while (to_idle && gen_active !== 1'b0) @(posedge pclk);
    endtask : drain

    // Any update with no note pending is an error
    always @(posedge pclk) begin
        if (presetn === 1'b1 && conv_upd === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, {ch1, ch0}, 32'h0);
            end else begin
                check({ch1, ch0}, exp_q.pop_front());
                check({31'h0, upd_clk}, {31'h0, hw_exp});
            end
        end
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            give_verdict();
        end
    end
    always #2.5 pclk = ~pclk;

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        start_trig = 1'b0;
        pause_trig = 1'b0;
        ext_clk = 1'b0;
        void'($urandom(28));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`WOS_ADDR_COUNT, 32'hFFFF_FFFF, `WOS_COUNT_RST);
        rd(`WOS_ADDR_PERIOD, 32'hFFFF_FFFF, 32'(`WOS_PERIOD_RST));
        rd(`WOS_ADDR_DELAY, 32'hFFFF_FFFF, 32'(`WOS_DELAY_RST));
        rd(`WOS_ADDR_TBDIV, 32'hFFFF_FFFF, 32'(`WOS_TBDIV_RST));
        rd(8'h20, 32'hFFFF_FFFF, 32'h0);
        check({31'h0, er_v}, 32'h1);
        wr(`WOS_ADDR_TBDIV, 32'h1);
        wr(`WOS_ADDR_PERIOD, 32'h3);
        // Software timed, one update per command
        hw_exp = 1'b0;
        wr(`WOS_ADDR_CTRL, 32'h10);
        load(3);
        wr(`WOS_ADDR_CTRL, 32'h10 | GO);
        for (int i = 0; i < 3; i++) begin
            exp_q.push_back(pend[i]);
            wr(`WOS_ADDR_CTRL, 32'h10 | (32'h1 << `WOS_CTRL_SWUPD));
        end
        drain(1'b0);
        check({31'h0, gen_active}, 32'h1);
        wr(`WOS_ADDR_CTRL, 32'h1 << `WOS_CTRL_STOP);
        hw_exp = 1'b1;
        // Finite run held until the start edge
        wr(`WOS_ADDR_COUNT, 32'h3);
        wr(`WOS_ADDR_CTRL, HW | TG);
        load(3);
        wr(`WOS_ADDR_CTRL, HW | TG | GO);
        repeat (30) @(posedge pclk);
        rd(`WOS_ADDR_STATUS, 32'h3, 32'h2);
        foreach (pend[i]) exp_q.push_back(pend[i]);
        start_trig <= 1'b1;
        drain(1'b1);
        rd(`WOS_ADDR_STATUS, 32'hFF, 32'h48);
        wr(`WOS_ADDR_STATUS, 32'hFF);
        rd(`WOS_ADDR_STATUS, 32'h1C, 32'h0);
        start_trig <= 1'b0;
        // Pause held from before the start
        pause_trig <= 1'b1;
        wr(`WOS_ADDR_CTRL, 32'h10 | HW | PS);
        load(2);
        wr(`WOS_ADDR_CTRL, 32'h10 | HW | PS | GO);
        repeat (40) @(posedge pclk);
        rd(`WOS_ADDR_STATUS, 32'h81, 32'h81);
        foreach (pend[i]) exp_q.push_back(pend[i]);
        pause_trig <= 1'b0;
        drain(1'b0);
        wr(`WOS_ADDR_CTRL, 32'h1 << `WOS_CTRL_STOP);
        // Non-regeneration runs dry
        wr(`WOS_ADDR_CTRL, 32'h30 | HW);
        load(2);
        foreach (pend[i]) exp_q.push_back(pend[i]);
        wr(`WOS_ADDR_CTRL, 32'h30 | HW | GO);
        drain(1'b1);
        rd(`WOS_ADDR_STATUS, 32'hFF, 32'h44);
        wr(`WOS_ADDR_STATUS, 32'hFF);
        // External update clock edge
        wr(`WOS_ADDR_CTRL, 32'h90 | HW);
        load(1);
        exp_q.push_back(pend[0]);
        wr(`WOS_ADDR_CTRL, 32'h90 | HW | GO);
        ext_clk <= 1'b1;
        drain(1'b0);
        ext_clk <= 1'b0;
        wr(`WOS_ADDR_CTRL, 32'h1 << `WOS_CTRL_STOP);
        // Slow ticks so the stop lands between updates
        wr(`WOS_ADDR_PERIOD, 32'd40);
        wr(`WOS_ADDR_CTRL, 32'h20 | HW);
        load(3);
        for (int i = 0; i < 7; i++) exp_q.push_back(pend[i % 3]);
        wr(`WOS_ADDR_CTRL, 32'h20 | HW | GO);
        host.push(32'h1234_5678, er_v);
        check({31'h0, er_v}, 32'h1);
        drain(1'b0);
        wr(`WOS_ADDR_CTRL, 32'h1 << `WOS_CTRL_STOP);
        rd(`WOS_ADDR_STATUS, 32'h01FF_0010, 32'h0003_0010);
        give_verdict();
    end
endmodule : wos_sequencer_tb
